//--- design/sram_host_ctrl.sv
// host controller driving an asynchronous ecc static memory
`timescale 1ns/10ps
`include "sram_ctrl_defs.svh"

module sram_host_ctrl
#(
    parameter int READ_WAIT  = `READ_WAIT_CYC,
    parameter int WRITE_LOW  = `WRITE_LOW_CYC,
    parameter int FLOAT_WAIT = `FLOAT_WAIT_CYC,
    parameter int CYCLE_GAP  = `CYCLE_GAP_CYC
)
(
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   clk_en,
    input  wire logic                   req_valid,
    output logic                        req_ready,
    input  wire sram_ctrl_pkg::mem_req_t req,
    output logic                        rsp_valid,
    output sram_ctrl_pkg::mem_rsp_t     rsp,
    output sram_ctrl_pkg::mem_pins_t    pins,
    input  wire logic [15:0]            data_in,
    output logic [15:0]                 data_out,
    output logic [15:0]                 data_oe,
    input  wire logic                   err_in
);
    import sram_ctrl_pkg::*;

    typedef enum logic [2:0] {IDLE, RD_SETUP, RD_WAIT, WR_SETUP, WR_LOW, WR_END, FLOAT, GAP}
        state_t;

    localparam int CW = 4;
    // depth of the pin synchronisers, added to the read wait
    localparam int SYNC_STAGES = 2;

    state_t      state;
    state_t      next_state;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic [CW-1:0] gap;
    logic [CW-1:0] next_gap;
    mem_req_t    cur;
    mem_req_t    next_cur;
    mem_pins_t   next_pins;
    logic [15:0] next_data_out;
    logic [15:0] next_data_oe;
    mem_rsp_t    next_rsp;
    logic        next_rsp_valid;
    logic [15:0] data_s1;
    logic [15:0] data_s2;
    logic        err_s1;
    logic        err_s2;
    logic [15:0] next_data_s1;
    logic [15:0] next_data_s2;
    logic        next_err_s1;
    logic        next_err_s2;
    logic [15:0] lane_mask;

    logic        take;
    logic        capture;

    // two-stage synchronisers on pins from the device
    always_comb
    begin
        next_data_s1 = data_in;
        next_data_s2 = data_s1;
        next_err_s1  = err_in;
        next_err_s2  = err_s1;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            data_s1 <= 16'h0000;
            data_s2 <= 16'h0000;
            err_s1  <= 1'b0;
            err_s2  <= 1'b0;
        end
        else if (clk_en)
        begin
            data_s1 <= next_data_s1;
            data_s2 <= next_data_s2;
            err_s1  <= next_err_s1;
            err_s2  <= next_err_s2;
        end
    end

    // only lanes with a low enable carry data
    for (genvar lane = 0; lane < 2; lane++)
    begin : g_lane
        assign lane_mask[lane*8 +: 8] = {8{~cur.lane_n[lane]}};
    end

    assign req_ready = (state == IDLE);
    // an access is taken only once the spacing window has run out
    assign take      = req_ready && req_valid && (gap == '0);
    assign capture   = (state == RD_WAIT) && (count == CW'(1));

    function automatic mem_pins_t idle_pins(input logic [20:0] a);
        mem_pins_t p;
        p.chip_select_low_active  = 1'b1;
        p.chip_select_high_active = 1'b0;
        p.write_strobe_n          = 1'b1;
        p.output_drive_n          = 1'b1;
        p.upper_lane_sel_n        = 1'b1;
        p.lower_lane_sel_n        = 1'b1;
        p.addr                    = a;
        return p;
    endfunction : idle_pins

    // spacing counter restarts at every accepted access
    always_comb
    begin
        next_gap = (gap != '0) ? gap - 1'b1 : gap;
        if (take)
        begin
            next_gap = CW'(CYCLE_GAP + 1);
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gap <= '0;
        end
        else if (clk_en)
        begin
            gap <= next_gap;
        end
    end

    // read result taken once address, enable and lane times have passed
    always_comb
    begin
        next_rsp       = rsp;
        next_rsp_valid = capture;
        if (capture)
        begin
            next_rsp.rdata     = data_s2 & lane_mask;
            next_rsp.corrected = err_s2;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rsp       <= '0;
            rsp_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            rsp       <= next_rsp;
            rsp_valid <= next_rsp_valid;
        end
    end

    // access sequencer: pins, write data and counters
    always_comb
    begin
        next_state     = state;
        next_count     = count;
        next_cur       = cur;
        next_pins      = pins;
        next_data_out  = data_out;
        next_data_oe   = data_oe;
        unique case (state)
            IDLE:
            begin
                if (take)
                begin
                    next_cur  = req;
                    // address placed before select goes active
                    next_pins = idle_pins(req.addr);
                    next_state = req.write ? WR_SETUP : RD_SETUP;
                end
            end
            RD_SETUP:
            begin
                // strobe kept high for the read
                next_pins.write_strobe_n          = 1'b1;
                next_pins.chip_select_low_active  = 1'b0;
                next_pins.chip_select_high_active = 1'b1;
                next_pins.output_drive_n          = 1'b0;
                next_pins.upper_lane_sel_n        = cur.lane_n[1];
                next_pins.lower_lane_sel_n        = cur.lane_n[0];
                // synchroniser delay added so data is sampled after the access time
                next_count = CW'(READ_WAIT + SYNC_STAGES);
                next_state = RD_WAIT;
            end
            RD_WAIT:
            begin
                // wait covers address, enable and lane access times
                if (capture)
                begin
                    // pins back to idle once the word is taken
                    next_pins  = idle_pins(cur.addr);
                    // let the device float before anything else
                    next_count = CW'(FLOAT_WAIT);
                    next_state = FLOAT;
                end
                else
                begin
                    next_count = count - 1'b1;
                end
            end
            WR_SETUP:
            begin
                // selects and strobe active, lanes as requested, drive disabled
                next_pins.output_drive_n          = 1'b1;
                next_pins.chip_select_low_active  = 1'b0;
                next_pins.chip_select_high_active = 1'b1;
                next_pins.upper_lane_sel_n        = cur.lane_n[1];
                next_pins.lower_lane_sel_n        = cur.lane_n[0];
                next_pins.write_strobe_n          = 1'b0;
                next_data_out = cur.wdata;
                // strobe width covers device float before our drive
                next_data_oe  = lane_mask;
                next_count    = CW'(WRITE_LOW);
                next_state    = WR_LOW;
            end
            WR_LOW:
            begin
                if (count == CW'(1))
                begin
                    // strobe rise terminates; address, lanes, data held
                    next_pins.write_strobe_n = 1'b1;
                    next_state = WR_END;
                end
                else
                begin
                    next_count = count - 1'b1;
                end
            end
            WR_END:
            begin
                // data, selects and lanes released after the ending edge, address kept
                next_pins    = idle_pins(cur.addr);
                next_data_oe = 16'h0000;
                next_count   = CW'(1);
                next_state   = FLOAT;
            end
            FLOAT:
            begin
                if (count == CW'(1))
                begin
                    next_state = GAP;
                end
                else
                begin
                    next_count = count - 1'b1;
                end
            end
            GAP:
            begin
                next_state = IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state     <= IDLE;
            count     <= '0;
            cur       <= '0;
            pins      <= idle_pins(21'h000000);
            data_out  <= 16'h0000;
            data_oe   <= 16'h0000;
        end
        else if (clk_en)
        begin
            state     <= next_state;
            count     <= next_count;
            cur       <= next_cur;
            pins      <= next_pins;
            data_out  <= next_data_out;
            data_oe   <= next_data_oe;
        end
    end
endmodule : sram_host_ctrl

//--- common/sram_ctrl_defs.svh
// timing constants for the ecc static memory host controller
`ifndef SRAM_CTRL_DEFS_SVH
`define SRAM_CTRL_DEFS_SVH
`define CLK_PERIOD_NS        20
`define READ_CYCLE_NS        55
`define ADDR_ACCESS_NS       55
`define OUTPUT_DRIVE_NS      25
`define LANE_ACCESS_NS       55
`define LANE_FLOAT_NS        18
`define ADDR_SETUP_END_NS    40
`define LANE_LOW_END_NS      40
`define WRITE_DATA_SETUP_NS  25
`define STROBE_FLOAT_NS      18
`define STROBE_WIDTH_NS      40
`define WRITE_CYCLE_NS       55
`define CEIL_CYC(ns)         (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX2(a, b)           (((a) > (b)) ? (a) : (b))
`define READ_WAIT_CYC        `CEIL_CYC(`MAX2(`ADDR_ACCESS_NS, `LANE_ACCESS_NS))
`define WRITE_LOW_CYC        `CEIL_CYC(`MAX2(`MAX2(`STROBE_WIDTH_NS, `ADDR_SETUP_END_NS), `MAX2(`LANE_LOW_END_NS, `STROBE_FLOAT_NS + `WRITE_DATA_SETUP_NS)))
`define FLOAT_WAIT_CYC       `CEIL_CYC(`LANE_FLOAT_NS)
`define CYCLE_GAP_CYC        `CEIL_CYC(`MAX2(`READ_CYCLE_NS, `WRITE_CYCLE_NS))
`endif

//--- common/sram_ctrl_pkg.sv
// types shared by the ecc static memory host controller
package sram_ctrl_pkg;
    typedef struct packed {
        logic        write;
        logic [20:0] addr;
        logic [1:0]  lane_n;
        logic [15:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic        corrected;
    } mem_rsp_t;

    typedef struct packed {
        logic        chip_select_low_active;
        logic        chip_select_high_active;
        logic        write_strobe_n;
        logic        output_drive_n;
        logic        upper_lane_sel_n;
        logic        lower_lane_sel_n;
        logic [20:0] addr;
    } mem_pins_t;
endpackage : sram_ctrl_pkg

//--- tb/sram_host_ctrl_monitor.sv
// assertion checker for the ecc memory host controller
`timescale 1ns/10ps
module sram_host_ctrl_monitor
#(parameter int READ_WAIT = 3, WRITE_LOW = 3, FLOAT_WAIT = 1, CYCLE_GAP = 3)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire sram_ctrl_pkg::mem_req_t req,
    input wire logic rsp_valid,
    input wire sram_ctrl_pkg::mem_rsp_t rsp,
    input wire sram_ctrl_pkg::mem_pins_t pins,
    input wire logic [15:0] data_in,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe,
    input wire logic err_in
);
    import sram_ctrl_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire sel = !pins.chip_select_low_active && pins.chip_select_high_active;
    wire ws  = pins.write_strobe_n;
    wire od  = pins.output_drive_n;
    wire [15:0] lane_bits = {{8{!pins.upper_lane_sel_n}}, {8{!pins.lower_lane_sel_n}}};
    sequence s_rd; req_valid && req_ready && clk_en && !req.write; endsequence
    sequence s_wr; req_valid && req_ready && clk_en && req.write; endsequence
    a_rsp_lat: assert property (s_rd |=> !rsp_valid[*6] ##1 rsp_valid)
        else $error("read answer late");
    a_wr_start: assert property (s_wr |-> ##2 (!ws && sel && $stable(pins.addr)))
        else $error("write start wrong");
    a_strobe_width: assert property ($fell(ws) |-> !ws[*3] ##1 ws)
        else $error("strobe width wrong");
    a_wr_hold: assert property (!ws && !$past(ws) |-> $stable(pins) && $stable(data_out))
        else $error("write not held");
    a_rd_strobe: assert property (!od |-> ws && data_oe == 16'h0)
        else $error("drive during read");
    a_rd_len: assert property ($fell(od) |-> (!od && sel && $stable(pins.addr))[*5] ##1 od)
        else $error("read too short");
    a_lane_oe: assert property (!ws |-> data_oe == lane_bits)
        else $error("lane drive wrong");
    a_req_gap: assert property (req_valid && req_ready && clk_en |=> !req_ready[*3])
        else $error("requests too close");
endmodule : sram_host_ctrl_monitor

bind sram_host_ctrl sram_host_ctrl_monitor #(.READ_WAIT(READ_WAIT), .WRITE_LOW(WRITE_LOW),
    .FLOAT_WAIT(FLOAT_WAIT), .CYCLE_GAP(CYCLE_GAP)) i_mon (.clk(clk), .reset_n(reset_n),
    .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .err_in(err_in));

//--- tb/sram_ecc_model.sv
// behavioural model of the ecc static memory
`timescale 1ns/10ps
module sram_ecc_model
#(parameter int ACC_NS = 55)
(
    input wire sram_ctrl_pkg::mem_pins_t pins,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe,
    input wire logic [20:0] err_addr,
    output logic [15:0] data_in,
    output logic err_in
);
    import sram_ctrl_pkg::*;
    logic [15:0] mem [int];
    logic [15:0] m, w;
    logic sel, rd;
    initial data_in = 16'h0;
    initial err_in = 1'b0;
    always @(pins)
    begin
        sel = !pins.chip_select_low_active && pins.chip_select_high_active;
        rd = sel && !pins.output_drive_n && pins.write_strobe_n;
        m = {{8{!pins.upper_lane_sel_n}}, {8{!pins.lower_lane_sel_n}}};
        w = mem.exists(pins.addr) ? mem[pins.addr] : 16'h0;
        data_in <= #10 ~data_in;
        err_in <= #10 ~err_in;
        data_in <= #(rd ? ACC_NS : 18) rd ? (w & m) | (~data_in & ~m) : ~data_in;
        err_in <= #(rd ? ACC_NS : 18) rd ? pins.addr == err_addr : ~err_in;
    end
    // undriven data bits store garbage
    always @(posedge pins.write_strobe_n)
        if (sel && m != 16'h0)
            mem[pins.addr] = (w & ~m) | ((data_out ^ ~data_oe) & m);
endmodule : sram_ecc_model

//--- tb/sram_host_ctrl_tb.sv
// self-checking bench for the ecc memory host controller
`timescale 1ns/10ps
`define CHK(a, b, s) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: %s", $time, s); end end
module sram_host_ctrl_tb;
    import sram_ctrl_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_ready, rsp_valid, err_in;
    mem_req_t req = '0;
    mem_rsp_t rsp, e;
    mem_pins_t pins;
    logic [15:0] data_in, data_out, data_oe, lf = 16'h51;
    logic [20:0] err_addr = 21'h0;
    logic [15:0] sh [int];
    mem_rsp_t exp_q [$];
    int mismatches = 0, n_checks = 0;
    always #10 clk = ~clk;
    sram_host_ctrl i_dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .err_in(err_in));
    sram_ecc_model i_mem (.pins(pins), .data_out(data_out), .data_oe(data_oe),
        .err_addr(err_addr), .data_in(data_in), .err_in(err_in));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic wait_rdy(input logic lvl);
        int i;
        for (i = 0; i < 40 && req_ready !== lvl; i++)
            @(negedge clk);
        if (i == 40)
        begin
            `CHK(1'b0, 1'b1, "ready timeout")
            give_verdict;
        end
    endtask : wait_rdy
    task automatic acc(input logic w, input logic [20:0] a, input logic [1:0] ln,
        input logic [15:0] d);
        logic [15:0] m, o;
        m = {{8{~ln[1]}}, {8{~ln[0]}}};
        o = sh.exists(a) ? sh[a] : 16'h0;
        wait_rdy(1'b1);
        req_valid = 1'b1;
        req = '{write: w, addr: a, lane_n: ln, wdata: d};
        wait_rdy(1'b0);
        req_valid = 1'b0;
        if (w)
            sh[a] = (o & ~m) | (d & m);
        else
            exp_q.push_back('{rdata: o & m, corrected: a == err_addr});
    endtask : acc
    always @(negedge clk)
        if (rsp_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                `CHK(1'b1, 1'b0, "answer with none pending")
            else
            begin
                e = exp_q.pop_front();
                `CHK(rsp, e, "read result")
            end
        end
    initial
    begin
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        acc(1'b1, 21'h0a5, 2'b00, 16'h1234);
        acc(1'b0, 21'h0a5, 2'b00, 16'h0);
        $display("test word done");
        for (int k = 0; k < 9; k++)
            acc(k % 3 == 0, 21'h40, 2'(k / 3), 16'hc3a0 + 16'(k));
        $display("test lanes done");
        wait_rdy(1'b1);
        err_addr = 21'h40;
        acc(1'b0, 21'h40, 2'b00, 16'h0);
        $display("test flag done");
        for (int k = 0; k < 24; k++)
        begin
            lf = lfsr(lf);
            acc(lf[0], {18'h0, lf[3:1]}, lf[5:4] == 2'b11 ? 2'b00 : lf[5:4], lf);
        end
        $display("test random done");
        for (int i = 0; i < 20 && exp_q.size() != 0; i++)
            @(negedge clk);
        `CHK(exp_q.size() == 0, 1'b1, "read answer missing")
        give_verdict;
    end
endmodule : sram_host_ctrl_tb
